//--- design/serial_char_io.sv
// Purpose: Character transmitter and receiver for a serial terminal
// Assumes: Bit time in ref_clk cycles is a parameter matching the terminal
// Notes:   Received words pass a two-entry buffer; a word finished while it is full is dropped
// What this block does
// RULE1 - Send one 8-bit parallel character serially
// RULE2 - Frame sent character with start and stop
// RULE3 - Send data bits unchanged, no code conversion
// RULE4 - Send bit timing follows terminal input rate
// RULE5 - Send uses shifter, 5-bit counter, three flags
// RULE6 - Receive one framed 8-bit character at once
// RULE7 - Hold received bits, drive as parallel word
// RULE8 - Receive uses down-counter, four flags, shifter
// RULE9 - Receive bit timing follows terminal output rate
// RULE10 - Deliver received bits unchanged
// RULE11 - Frame: start low, 8 LSB-first, 2 stops
// RULE12 - Half-bit start check, then mid-bit samples
`timescale 1ns/1ps
module serial_char_io #(
	parameter int unsigned BIT_CYC = serial_char_pkg::BIT_CYC_DEF
) (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       resetn,
	// Parallel send side
	input  wire logic       tx_valid,
	output logic            tx_ready,
	input  wire logic [7:0] tx_data,
	// Parallel receive side
	output logic            rx_valid,
	input  wire logic       rx_ready,
	output logic      [7:0] rx_data,
	output logic            rx_frame_err,
	// Serial line
	output logic            ser_out,
	input  wire logic       ser_in
);
	import serial_char_pkg::*;

	localparam logic [CNT_W-1:0] BIT_TOP  = CNT_W'(BIT_CYC - 1);
	localparam logic [CNT_W-1:0] HALF_TOP = CNT_W'(BIT_CYC / 2 - 1);
	localparam logic [4:0]       TX_LAST  = 5'(FRAME_BITS - 1);
	localparam logic [3:0]       RX_LAST  = 4'(DATA_BITS);

	typedef struct packed {
		// Send side
		logic [CNT_W-1:0] tx_div;
		logic [7:0]       tx_sh;
		logic [4:0]       tx_cnt;
		logic             tx_busy;
		logic             tx_start;
		logic             tx_line;
		// Receive side
		logic [CNT_W-1:0] rx_down;
		logic [7:0]       rx_sh;
		logic [3:0]       rx_bit;
		logic             rx_busy;
		logic             rx_hunt;
		logic             rx_push;
		logic             rx_err;
		logic             sync1;
		logic             sync2;
		logic             sync3;
	} state_t;
	state_t st_ff;
	state_t nxt_st;

	logic       buf_ready;
	logic       tx_tick;
	logic       rx_tick;

	// Bit-rate enables from the dividers
	assign tx_tick  = st_ff.tx_busy && (st_ff.tx_div == '0); // RULE4
	assign rx_tick  = st_ff.rx_busy && (st_ff.rx_down == '0); // RULE9
	assign tx_ready = !st_ff.tx_busy;
	assign ser_out  = st_ff.tx_line;
	assign rx_frame_err = st_ff.rx_err;

	// Next state for both directions
	always_comb begin
		nxt_st       = st_ff;
		nxt_st.sync1 = ser_in;
		nxt_st.sync2 = st_ff.sync1;
		nxt_st.sync3 = st_ff.sync2;
		nxt_st.rx_push = 1'b0;
		// Transmit: load, start bit, 8 data LSB first, 2 stops
		if (!st_ff.tx_busy) begin
			if (tx_valid) begin
				nxt_st.tx_sh    = tx_data; // RULE1 RULE3
				nxt_st.tx_busy  = 1'b1;
				nxt_st.tx_start = 1'b1;
				nxt_st.tx_cnt   = TX_CNT_RST;
				nxt_st.tx_div   = BIT_TOP;
				nxt_st.tx_line  = LINE_START; // RULE2 RULE11
			end
		end else if (tx_tick) begin
			nxt_st.tx_div = BIT_TOP;
			if (st_ff.tx_cnt == TX_LAST) begin
				nxt_st.tx_busy = 1'b0; // RULE5
				nxt_st.tx_line = LINE_IDLE;
			end else begin
				nxt_st.tx_cnt   = 5'(st_ff.tx_cnt + 5'd1); // RULE5
				nxt_st.tx_start = 1'b0;
				if (st_ff.tx_cnt < 5'(DATA_BITS)) begin
					nxt_st.tx_line = st_ff.tx_sh[0]; // RULE11
					nxt_st.tx_sh   = {1'b0, st_ff.tx_sh[7:1]};
				end else begin
					nxt_st.tx_line = LINE_IDLE; // RULE2
				end
			end
		end else begin
			nxt_st.tx_div = CNT_W'(st_ff.tx_div - 1'b1);
		end
		// Receive: hunt a falling edge, confirm at half bit
		if (!st_ff.rx_busy) begin
			if (st_ff.sync3 && !st_ff.sync2) begin
				nxt_st.rx_busy = 1'b1;
				nxt_st.rx_hunt = 1'b1;
				nxt_st.rx_down = HALF_TOP; // RULE12
				nxt_st.rx_bit  = 4'd0;
			end
		end else if (rx_tick) begin
			nxt_st.rx_down = BIT_TOP; // RULE8
			if (st_ff.rx_hunt) begin
				nxt_st.rx_hunt = 1'b0;
				if (st_ff.sync2 != LINE_START) begin
					nxt_st.rx_busy = 1'b0; // RULE12
				end
			end else if (st_ff.rx_bit < RX_LAST) begin
				nxt_st.rx_sh  = {st_ff.sync2, st_ff.rx_sh[7:1]}; // RULE10
				nxt_st.rx_bit = 4'(st_ff.rx_bit + 4'd1); // RULE6
			end else begin
				// First stop bit sampled; word goes out if the buffer has room
				nxt_st.rx_busy = 1'b0;
				nxt_st.rx_err  = (st_ff.sync2 != LINE_IDLE);
				nxt_st.rx_push = buf_ready; // RULE7
			end
		end else begin
			nxt_st.rx_down = CNT_W'(st_ff.rx_down - 1'b1); // RULE8
		end
	end

	// State register
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			st_ff         <= '0;
			st_ff.tx_line <= LINE_IDLE;
			st_ff.sync1   <= LINE_IDLE;
			st_ff.sync2   <= LINE_IDLE;
			st_ff.sync3   <= LINE_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Received words wait here for the reader
	char_buf2 #(
		.WIDTH(8)
	) u_rx_buf (
		.ref_clk  (ref_clk),
		.resetn   (resetn),
		.in_valid (st_ff.rx_push),
		.in_ready (buf_ready),
		.in_data  (st_ff.rx_sh),
		.out_valid(rx_valid),
		.out_ready(rx_ready),
		.out_data (rx_data)
	);

	// Checks share the one clock and stay quiet while reset is low
	default clocking chk_clk @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	// Send side: line idles high between characters
	chk_tx_idle_high: assert property ( // RULE2
		!st_ff.tx_busy |-> ser_out)
		else $error("idle line not high");

	// Start bit: low at once and for as long as the start flag stands
	chk_tx_start_low: assert property ( // RULE11
		tx_valid && tx_ready |=> !ser_out[*3])
		else $error("start bit not low");
	chk_tx_start_flag: assert property ( // RULE2
		st_ff.tx_start |-> !ser_out)
		else $error("start flag with line high");

	// Character is taken whole and leaves least significant bit first
	chk_tx_load_word: assert property ( // RULE3
		tx_valid && tx_ready |=> st_ff.tx_sh == $past(tx_data))
		else $error("loaded character changed");
	chk_tx_first_bit: assert property ( // RULE11
		tx_tick && st_ff.tx_start |=> ser_out == $past(st_ff.tx_sh[0]))
		else $error("first data bit wrong");

	// Both stop bits high; counter never passes the last bit time
	chk_tx_stop_high: assert property ( // RULE2
		tx_tick && (st_ff.tx_cnt >= 5'(DATA_BITS)) |=> ser_out)
		else $error("stop bit not high");
	chk_tx_cnt_range: assert property ( // RULE5
		st_ff.tx_cnt <= TX_LAST)
		else $error("send counter overrun");
	chk_tx_busy_hold: assert property ( // RULE1
		tx_valid && tx_ready |=> !tx_ready[*8])
		else $error("send not held busy");
	chk_tx_stop_end: assert property ( // RULE2
		$rose(tx_ready) |-> $past(ser_out))
		else $error("stop not high");

	// Receive side: a start that is high again at half bit is dropped
	chk_rx_false_start: assert property ( // RULE12
		rx_tick && st_ff.rx_hunt && st_ff.sync2 |=> !st_ff.rx_busy)
		else $error("false start accepted");
	chk_rx_bit_range: assert property ( // RULE6
		st_ff.rx_bit <= RX_LAST)
		else $error("receive count overrun");

	// A finished word reaches the buffer unchanged and is offered
	chk_rx_push_data: assert property ( // RULE7
		st_ff.rx_push |-> ##1 $stable(st_ff.rx_sh))
		else $error("pushed word changed");
	chk_rx_word_out: assert property ( // RULE7
		st_ff.rx_push |=> rx_valid)
		else $error("pushed word not offered");

	// Main scenarios
	cov_tx_frame: cover property ($rose(tx_ready));
	cov_rx_word: cover property (st_ff.rx_push);
	cov_rx_stall: cover property (!buf_ready);
	cov_rx_err: cover property ($rose(rx_frame_err));
	cov_rx_false: cover property (rx_tick && st_ff.rx_hunt && st_ff.sync2);
endmodule

//--- design/serial_char_pkg.sv
// Purpose: Shared constants for the serial character send/receive block
// Assumes: 20 MHz ref_clk, terminal bit rate set by a divider parameter
// Notes:   Frame is one start bit, eight data bits, two stop bits
package serial_char_pkg;
	localparam int unsigned CLK_HZ        = 20000000;
	localparam int unsigned BAUD_DEFAULT  = 110;
	localparam int unsigned DATA_BITS     = 8;
	localparam int unsigned STOP_BITS     = 2;
	localparam int unsigned FRAME_BITS    = 1 + DATA_BITS + STOP_BITS;
	localparam int unsigned BIT_CYC_DEF   = CLK_HZ / BAUD_DEFAULT;
	localparam int unsigned CNT_W         = 20;
	localparam logic        LINE_IDLE     = 1'b1;
	localparam logic        LINE_START    = 1'b0;
	localparam logic [7:0]  SHIFT_RST     = 8'h00;
	localparam logic [4:0]  TX_CNT_RST    = 5'h00;
endpackage

//--- design/char_buf2.sv
// Purpose: Two-entry buffer between the receiver and its reader
// Assumes: One clock, asynchronous active-low reset
// Notes:   in_ready drops only when both entries are full
`timescale 1ns/1ps
module char_buf2 #(
	parameter int unsigned WIDTH = 8
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             resetn,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	typedef struct packed {
		logic [1:0][WIDTH-1:0] mem;
		logic                  rd;
		logic [1:0]            cnt;
	} buf_t;
	buf_t st_ff;
	buf_t nxt_st;
	logic push;
	logic pop;

	// Handshakes
	assign in_ready  = (st_ff.cnt != 2'd2);
	assign out_valid = (st_ff.cnt != 2'd0);
	assign out_data  = st_ff.mem[st_ff.rd];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Next state
	always_comb begin
		nxt_st = st_ff;
		if (push) begin
			nxt_st.mem[st_ff.rd ^ st_ff.cnt[0]] = in_data;
		end
		if (pop) begin
			nxt_st.rd = ~st_ff.rd;
		end
		nxt_st.cnt = 2'(st_ff.cnt + {1'b0, push} - {1'b0, pop});
	end

	// State register
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Checks
	chk_buf_no_over: assert property (@(posedge ref_clk) disable iff (!resetn)
		st_ff.cnt <= 2'd2) else $error("buffer count out of range");
endmodule

//--- dv/term_model.sv
// Purpose: Terminal model on the serial side of the block
// Assumes: Both directions use BIT_CYC ref_clk cycles per bit
// Notes:   Line idles high; frames decoded at mid-bit and counted
`timescale 1ns/1ps
module term_model #(
	parameter int unsigned BIT_CYC = 8
) (
	// Clock
	input  wire logic       ref_clk,
	// Commands from the bench
	input  wire logic       send_go,
	input  wire logic [7:0] send_char,
	input  wire logic       send_bad,
	input  wire logic       send_short,
	// Serial line
	input  wire logic       ser_out,
	output logic            ser_in,
	// Decoded frames
	output logic      [7:0] got_char,
	output logic            got_stop_ok,
	output int              got_n
);
	initial begin
		ser_in = 1'b1;
		got_char = 8'h00;
		got_stop_ok = 1'b0;
		got_n = 0;
	end
	// Send one frame; a bad frame has both stop bits low
	// A short command gives a low pulse of a quarter bit only
	always @(posedge ref_clk) begin
		if (send_go && send_short) begin
			ser_in <= 1'b0;
			repeat (BIT_CYC / 4) @(posedge ref_clk);
			ser_in <= 1'b1;
		end else if (send_go) begin
			ser_in <= 1'b0;
			repeat (BIT_CYC) @(posedge ref_clk);
			for (int i = 0; i < 8; i++) begin
				ser_in <= send_char[i];
				repeat (BIT_CYC) @(posedge ref_clk);
			end
			ser_in <= ~send_bad;
			repeat (2 * BIT_CYC) @(posedge ref_clk);
			ser_in <= 1'b1;
		end
	end
	// Decode frames from the block, sampling at mid-bit
	always @(negedge ser_out) begin
		repeat (BIT_CYC / 2) @(posedge ref_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge ref_clk);
			got_char[i] = ser_out;
		end
		repeat (BIT_CYC) @(posedge ref_clk);
		got_stop_ok = ser_out;
		repeat (BIT_CYC) @(posedge ref_clk);
		got_stop_ok = got_stop_ok & ser_out;
		got_n++;
	end
endmodule

//--- dv/test_serial_char_io.sv
// Purpose: Self-checking bench for the serial character block
// Assumes: Bit time shortened to eight ref_clk cycles
// Notes:   Rows are sent both ways, by the block and by the terminal; expected output equals the input
`timescale 1ns/1ps
module test_serial_char_io;
	import serial_char_pkg::*;
	localparam int unsigned BC = 8;
	logic       ref_clk = 1'b0;
	logic       resetn = 1'b0;
	logic       tx_valid = 1'b0;
	logic [7:0] tx_data = 8'h00;
	logic       rx_ready = 1'b0;
	logic       send_go = 1'b0;
	logic       send_bad = 1'b0;
	logic [7:0] send_char = 8'h00;
	logic       send_short = 1'b0;
	logic       tx_ready, rx_valid, rx_frame_err, ser_out, ser_in;
	logic [7:0] rx_data, got_char;
	logic       got_stop_ok;
	int         got_n, n0;
	int         n_fail = 0;
	int         n_checks = 0;
	// Each row: character sent in the upper byte, expected in the lower
	logic [15:0] rows [6] = '{16'h0000, 16'hffff, 16'ha5a5, 16'h5a5a,
		16'h0101, 16'h8080};
	// Clock of 50 ns
	always #25 ref_clk = ~ref_clk;
	serial_char_io #(.BIT_CYC(BC)) u_dut (.ref_clk(ref_clk),
		.resetn(resetn), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.rx_data(rx_data), .rx_frame_err(rx_frame_err),
		.ser_out(ser_out), .ser_in(ser_in));
	term_model #(.BIT_CYC(BC)) u_term (.ref_clk(ref_clk),
		.send_go(send_go), .send_char(send_char), .send_bad(send_bad),
		.send_short(send_short),
		.ser_out(ser_out), .ser_in(ser_in), .got_char(got_char),
		.got_stop_ok(got_stop_ok), .got_n(got_n));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %h vs %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		if (n_fail == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Wait: -1 word ready, -2 send idle, else decoded count
	task automatic wait_ev(input int n);
		for (int k = 0; k < 500; k++) begin
			@(negedge ref_clk);
			if (n == -1 ? rx_valid === 1'b1 : n == -2 ?
				tx_ready === 1'b1 : got_n >= n)
				return;
		end
		n_fail++;
		end_sim();
	endtask
	// Offer c to the sender and have the terminal send c too
	task automatic send(input logic [7:0] c, input logic bad);
		wait_ev(-2);
		@(posedge ref_clk);
		tx_valid <= 1'b1;
		tx_data <= c;
		send_go <= 1'b1;
		send_char <= c;
		send_bad <= bad;
		@(posedge ref_clk);
		tx_valid <= 1'b0;
		send_go <= 1'b0;
	endtask
	task automatic pop(input logic [7:0] c);
		wait_ev(-1);
		check(rx_data, c);
		@(posedge ref_clk);
		rx_ready <= 1'b1;
		@(posedge ref_clk);
		rx_ready <= 1'b0;
	endtask
	initial begin
		repeat (16) @(posedge ref_clk);
		check(ser_out, LINE_IDLE);
		check({tx_ready, rx_valid, rx_frame_err}, 3'b100);
		check(rx_data, 8'h00);
		resetn <= 1'b1;
		// Row loop: each row sent both ways
		foreach (rows[i]) begin
			n0 = got_n;
			send(rows[i][15:8], 1'b0);
			pop(rows[i][7:0]);
			check(rx_frame_err, 1'b0);
			wait_ev(n0 + 1);
			check(got_char, rows[i][7:0]);
			check(got_stop_ok, 1'b1);
		end
		// Buffer full: third unread word is dropped
		send(8'h11, 1'b0);
		send(8'h22, 1'b0);
		send(8'h33, 1'b0);
		repeat (12 * BC) @(negedge ref_clk);
		pop(8'h11);
		pop(8'h22);
		repeat (4) @(negedge ref_clk);
		check(rx_valid, 1'b0);
		// Short low pulse on the line is no start bit
		@(posedge ref_clk);
		send_go <= 1'b1;
		send_short <= 1'b1;
		@(posedge ref_clk);
		send_go <= 1'b0;
		send_short <= 1'b0;
		repeat (12 * BC) @(negedge ref_clk);
		check(rx_valid, 1'b0);
		// Stop bit low flags a frame error
		send(8'h3c, 1'b1);
		pop(8'h3c);
		check(rx_frame_err, 1'b1);
		// Reset in mid-frame returns tx_ready, ser_out, rx_valid and rx_frame_err to idle
		wait_ev(-2);
		@(posedge ref_clk);
		tx_valid <= 1'b1;
		tx_data <= 8'h0f;
		@(posedge ref_clk);
		tx_valid <= 1'b0;
		repeat (3 * BC) @(posedge ref_clk);
		resetn <= 1'b0;
		@(negedge ref_clk);
		check({tx_ready, ser_out, rx_valid, rx_frame_err}, 4'hc);
		@(posedge ref_clk);
		resetn <= 1'b1;
		// Work resumes after the second reset
		send(8'h96, 1'b0);
		pop(8'h96);
		check(rx_frame_err, 1'b0);
		end_sim();
	end
endmodule
